// >>> core/lin_position_sleep_cmd_decoder.sv
// Positioner end: decodes short-position, position-with-parameters and sleep frames.
`timescale 1ns/1ps
`include "lin_cmd_params.svh"

module lin_position_sleep_cmd_decoder (
    input wire logic pclk,
    input wire logic presetn,
    lin_frame_if.device lnk,
    input wire logic [5:0] short_frame_id,
    input wire logic [5:0] param_frame_id,
    input wire logic [3:0] physical_address_bits,
    input wire logic sleep_permit_flag,
    input wire logic [10:0] secure_position,
    input wire logic motion_active,
    output logic [15:0] target_position,
    output logic target_short,
    output logic target_load,
    output logic [3:0] max_velocity_field,
    output logic [3:0] min_velocity_field,
    output logic [3:0] stall_threshold_field,
    output logic [3:0] accel_field,
    output logic params_load,
    output logic decelerating_halt,
    output logic sleep_enter,
    output logic stop_enter,
    output logic frame_error
);

    // ------------------------------------------------------------------
    // Frame capture
    // ------------------------------------------------------------------
    logic [7:0] id_q;
    logic [7:0] data_q [0:7];
    logic [3:0] cnt_q;
    logic [7:0] sum_q;
    logic ovf_q;
    logic in_frame_q;

    wire data_byte = lnk.byte_valid && !lnk.byte_first && !lnk.byte_last && in_frame_q;
    wire frame_end = lnk.byte_valid && lnk.byte_last && in_frame_q;

    // Identifier opens a frame; data bytes are stored and summed.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            id_q <= 8'h00;
            cnt_q <= 4'h0;
            sum_q <= 8'h00;
            ovf_q <= 1'b0;
            in_frame_q <= 1'b0;
        end else if (lnk.byte_valid && lnk.byte_first) begin
            id_q <= lnk.byte_data;
            cnt_q <= 4'h0;
            sum_q <= 8'h00;
            ovf_q <= 1'b0;
            in_frame_q <= 1'b1;
        end else if (data_byte) begin
            if (cnt_q == 4'h8) begin
                ovf_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
            sum_q <= lin_cmd_pkg::csum_add(sum_q, lnk.byte_data);
        end else if (frame_end) begin
            in_frame_q <= 1'b0;
        end
    end

    // Data byte store, one slot per position in the frame.
    always_ff @(posedge pclk) begin
        if (data_byte && cnt_q < 4'h8) begin
            data_q[cnt_q[2:0]] <= lnk.byte_data;
        end
    end

    // ------------------------------------------------------------------
    // Frame checks
    // ------------------------------------------------------------------
    // A frame is usable only with good parity, good checksum and no overrun.
    wire parity_ok = (lin_cmd_pkg::protect_id(id_q[5:0]) == id_q);
    wire csum_ok = (lin_cmd_pkg::csum_add(sum_q, lnk.byte_data) == `CSUM_GOOD);
    wire frame_ok = frame_end && parity_ok && csum_ok && !ovf_q;
    wire frame_bad = frame_end && !(parity_ok && csum_ok && !ovf_q);

    // Short frame: bits 5:4 set and the whole identifier is the allocated one.
    wire is_short = frame_ok && (id_q[5:4] == `SHORT4_ID_HIGH)
        && (id_q[5:0] == short_frame_id)
        && (cnt_q == `SHORT4_DATA_BYTES);

    // Parameter frame: this node's own parameter identifier, four bytes.
    wire is_param = frame_ok && (id_q[5:0] == param_frame_id)
        && (cnt_q == `PARAM_DATA_BYTES);

    // Sleep frame: fixed identifier and fixed content, no address involved.
    wire sleep_fill = (data_q[1] == `SLEEP_FILL_BYTE) && (data_q[2] == `SLEEP_FILL_BYTE)
        && (data_q[3] == `SLEEP_FILL_BYTE) && (data_q[4] == `SLEEP_FILL_BYTE)
        && (data_q[5] == `SLEEP_FILL_BYTE) && (data_q[6] == `SLEEP_FILL_BYTE)
        && (data_q[7] == `SLEEP_FILL_BYTE);
    wire is_sleep = frame_ok && (id_q == `SLEEP_ID) && (cnt_q == `SLEEP_DATA_BYTES)
        && (data_q[0] == `SLEEP_FIRST_BYTE) && sleep_fill;

    // ------------------------------------------------------------------
    // Byte pair selection for the short frame
    // ------------------------------------------------------------------
    logic short_hit;
    logic [10:0] short_pos;

    // Scans the four pairs; a later matching pair overrides an earlier one.
    always_comb begin
        short_hit = 1'b0;
        short_pos = 11'h000;
        for (int i = 0; i < 4; i++) begin
            if (data_q[2 * i][`SHORT_FIXED_BIT]
                && data_q[2 * i][3:0] == physical_address_bits) begin
                short_hit = 1'b1;
                short_pos = {data_q[2 * i][7:`SHORT_POS_HI_LSB], data_q[2 * i + 1]};
            end
        end
    end

    // ------------------------------------------------------------------
    // Sleep sequencing
    // ------------------------------------------------------------------
    lin_cmd_pkg::sleep_state_e sl_q;
    lin_cmd_pkg::sleep_state_e sl_d;
    wire secure_valid = (secure_position != `SECURE_POS_NONE);
    wire sleep_start = is_sleep && (sl_q == lin_cmd_pkg::SL_IDLE);
    wire sleep_moving = sleep_start && motion_active;

    // Waits for the motor to settle before the final sleep or stop step.
    always_comb begin
        case (sl_q)
            lin_cmd_pkg::SL_IDLE: begin
                if (sleep_moving) begin
                    sl_d = lin_cmd_pkg::SL_WAIT;
                end else if (sleep_start) begin
                    sl_d = lin_cmd_pkg::SL_ENTER;
                end else begin
                    sl_d = lin_cmd_pkg::SL_IDLE;
                end
            end
            lin_cmd_pkg::SL_WAIT: begin
                sl_d = motion_active ? lin_cmd_pkg::SL_WAIT : lin_cmd_pkg::SL_ENTER;
            end
            lin_cmd_pkg::SL_ENTER: begin
                sl_d = lin_cmd_pkg::SL_IDLE;
            end
            default: begin
                sl_d = lin_cmd_pkg::SL_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sl_q <= lin_cmd_pkg::SL_IDLE;
        end else begin
            sl_q <= sl_d;
        end
    end

    // ------------------------------------------------------------------
    // Target and parameter outputs
    // ------------------------------------------------------------------
    logic [15:0] target_position_q;
    logic target_short_q;
    logic target_load_q;
    logic [3:0] max_velocity_field_q;
    logic [3:0] vmin_q;
    logic [3:0] thr_q;
    logic [3:0] acc_q;
    logic params_load_q;
    logic halt_q;
    logic sleep_enter_q;
    logic stop_enter_q;
    logic frame_error_q;

    wire load_short = is_short && short_hit;
    wire load_secure = sleep_moving && secure_valid;

    // Short targets are half-step counts, sign-extended to sixteen bits.
    wire [15:0] short_ext = {{5{short_pos[10]}}, short_pos};
    wire [15:0] secure_ext = {{5{secure_position[10]}}, secure_position};
    wire [15:0] param_pos = {data_q[0], data_q[1]};

    // Target register: one source per cycle, frames cannot overlap.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            target_position_q <= 16'h0000;
            target_short_q <= 1'b0;
            target_load_q <= 1'b0;
        end else begin
            target_load_q <= load_short || is_param || load_secure;
            if (load_short) begin
                target_position_q <= short_ext;
                target_short_q <= 1'b1;
            end else if (is_param) begin
                target_position_q <= param_pos;
                target_short_q <= 1'b0;
            end else if (load_secure) begin
                target_position_q <= secure_ext;
                target_short_q <= 1'b1;
            end
        end
    end

    // Motion parameters follow the same parameter frame as the target.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            max_velocity_field_q <= 4'h0;
            vmin_q <= 4'h0;
            thr_q <= 4'h0;
            acc_q <= 4'h0;
            params_load_q <= 1'b0;
        end else begin
            params_load_q <= is_param;
            if (is_param) begin
                max_velocity_field_q <= data_q[2][7:4];
                vmin_q <= data_q[2][3:0];
                thr_q <= data_q[3][7:4];
                acc_q <= data_q[3][3:0];
            end
        end
    end

    // One-cycle event pulses for the motion controller.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halt_q <= 1'b0;
            sleep_enter_q <= 1'b0;
            stop_enter_q <= 1'b0;
            frame_error_q <= 1'b0;
        end else begin
            halt_q <= sleep_moving && !secure_valid;
            sleep_enter_q <= (sl_q == lin_cmd_pkg::SL_ENTER) && sleep_permit_flag;
            stop_enter_q <= (sl_q == lin_cmd_pkg::SL_ENTER) && !sleep_permit_flag;
            frame_error_q <= frame_bad;
        end
    end

    // ------------------------------------------------------------------
    // Port drive
    // ------------------------------------------------------------------
    assign target_position = target_position_q;
    assign target_short = target_short_q;
    assign target_load = target_load_q;
    assign max_velocity_field = max_velocity_field_q;
    assign min_velocity_field = vmin_q;
    assign stall_threshold_field = thr_q;
    assign accel_field = acc_q;
    assign params_load = params_load_q;
    assign decelerating_halt = halt_q;
    assign sleep_enter = sleep_enter_q;
    assign stop_enter = stop_enter_q;
    assign frame_error = frame_error_q;

endmodule

// >>> core/lin_cmd_params.svh
// Constants for the position, parameter and sleep frame decoder and its controller.
`ifndef LIN_CMD_PARAMS_SVH
`define LIN_CMD_PARAMS_SVH

// ----------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------
`define SHORT4_DATA_BYTES 4'h8
`define PARAM_DATA_BYTES 4'h4
`define SLEEP_DATA_BYTES 4'h8
`define SHORT4_ID_HIGH 2'h3
`define SLEEP_ID 8'h3c
`define SLEEP_FIRST_BYTE 8'h00
`define SLEEP_FILL_BYTE 8'hff
`define SHORT_FIXED_BIT 4
`define SHORT_ADDR_LSB 0
`define SHORT_POS_HI_LSB 5
`define SECURE_POS_NONE 11'h400
`define CSUM_GOOD 8'hff

// ----------------------------------------------------------------------
// Controller register map (APB byte offsets) and fields
// ----------------------------------------------------------------------
`define REG_CTRL 12'h000
`define REG_DATA_LO 12'h004
`define REG_DATA_HI 12'h008
`define REG_STATUS 12'h00c
`define CTRL_KIND_LSB 0
`define CTRL_ID_LSB 8
`define CTRL_GO_BIT 31
`define STATUS_BUSY_BIT 0
`define STATUS_REFUSED_BIT 1

`endif

// >>> core/lin_cmd_pkg.sv
// Types and shared helpers for the frame decoder and its controller.
package lin_cmd_pkg;

    // Command kinds the controller can send.
    typedef enum logic [1:0] {
        KIND_SHORT4 = 2'h0,
        KIND_PARAM = 2'h1,
        KIND_SLEEP = 2'h2
    } cmd_kind_e;

    // Controller frame sequencer, Gray coded along the send path.
    typedef enum logic [1:0] {
        TX_IDLE = 2'h0,
        TX_ID = 2'h1,
        TX_DATA = 2'h3,
        TX_CHK = 2'h2
    } tx_state_e;

    // Sleep handling in the device, not Gray coded: SL_ENTER to SL_IDLE flips both bits.
    typedef enum logic [1:0] {
        SL_IDLE = 2'h0,
        SL_WAIT = 2'h1,
        SL_ENTER = 2'h3
    } sleep_state_e;

    // Adds the two parity bits on top of a six-bit identifier.
    function automatic logic [7:0] protect_id(input logic [5:0] id);
        logic p0;
        logic p1;
        p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
        p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
        return {p1, p0, id};
    endfunction

    // Eight-bit sum with the carry folded back in.
    function automatic logic [7:0] csum_add(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[7:0] + {7'h00, s[8]};
    endfunction

endpackage

// >>> core/lin_frame_if.sv
// Byte-level frame link between the bus controller and the positioner decoder.
`timescale 1ns/1ps
interface lin_frame_if;
    logic byte_valid;
    logic [7:0] byte_data;
    logic byte_first;
    logic byte_last;

    // The controller sends protected identifier, data bytes and checksum.
    modport controller (
        output byte_valid,
        output byte_data,
        output byte_first,
        output byte_last
    );

    // The device only listens.
    modport device (
        input byte_valid,
        input byte_data,
        input byte_first,
        input byte_last
    );
endinterface

// >>> core/lin_cmd_controller.sv
// Bus master end: APB-programmed sender of short-position, parameter and sleep frames.
`timescale 1ns/1ps
`include "lin_cmd_params.svh"

module lin_cmd_controller (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    lin_frame_if.controller lnk
);

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [1:0] kind_q;
    logic [5:0] id_q;
    logic [63:0] data_q;
    logic busy_q;
    logic refused_q;

    wire access = psel && penable && !pready_q;
    wire done = psel && penable && pready_q;
    wire hit_ctrl = (paddr == `REG_CTRL);
    wire hit_lo = (paddr == `REG_DATA_LO);
    wire hit_hi = (paddr == `REG_DATA_HI);
    wire hit_stat = (paddr == `REG_STATUS);
    wire mapped = hit_ctrl || hit_lo || hit_hi || hit_stat;
    wire wr = done && pwrite && mapped;
    wire go = wr && hit_ctrl && pwdata[`CTRL_GO_BIT];
    wire [31:0] rd_mux = hit_ctrl ? {18'h00000, id_q, 6'h00, kind_q} :
        hit_lo ? data_q[31:0] :
        hit_hi ? data_q[63:32] :
        hit_stat ? {30'h00000000, refused_q, busy_q} : 32'h00000000;

    // Answers one cycle into the access phase; unmapped addresses flag an error.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= access;
            pslverr_q <= access && !mapped;
            prdata_q <= (access && !pwrite) ? rd_mux : 32'h00000000;
        end
    end

    // Command registers; writes are refused while a frame is being sent.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kind_q <= 2'h0;
            id_q <= 6'h00;
            data_q <= 64'h0000000000000000;
            refused_q <= 1'b0;
        end else if (wr && busy_q && !hit_stat) begin
            refused_q <= 1'b1;
        end else if (wr && hit_ctrl) begin
            kind_q <= pwdata[`CTRL_KIND_LSB +: 2];
            id_q <= pwdata[`CTRL_ID_LSB +: 6];
            refused_q <= 1'b0;
        end else if (wr && hit_lo) begin
            data_q[31:0] <= pwdata;
        end else if (wr && hit_hi) begin
            data_q[63:32] <= pwdata;
        end
    end

    // ------------------------------------------------------------------
    // Frame sender
    // ------------------------------------------------------------------
    lin_cmd_pkg::tx_state_e st_q;
    logic [3:0] idx_q;
    logic [7:0] sum_q;
    logic valid_q;
    logic first_q;
    logic last_q;
    logic [7:0] byte_q;

    wire is_sleep = (kind_q == lin_cmd_pkg::KIND_SLEEP);
    wire is_param = (kind_q == lin_cmd_pkg::KIND_PARAM);
    wire [7:0] sleep_id = `SLEEP_ID;
    wire [5:0] raw_id = is_sleep ? sleep_id[5:0] :
        is_param ? id_q : {`SHORT4_ID_HIGH, id_q[3:0]};
    wire [3:0] nbytes = is_param ? `PARAM_DATA_BYTES : `SHORT4_DATA_BYTES;
    wire [7:0] user_byte = data_q[{idx_q[2:0], 3'h0} +: 8];
    wire [7:0] sleep_byte = (idx_q == 4'h0) ? `SLEEP_FIRST_BYTE : `SLEEP_FILL_BYTE;
    wire [7:0] next_byte = is_sleep ? sleep_byte : user_byte;
    wire start = go && !busy_q && !refused_q;

    // Sends identifier, data bytes in order and the inverted carry sum.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= lin_cmd_pkg::TX_IDLE;
            idx_q <= 4'h0;
            sum_q <= 8'h00;
            busy_q <= 1'b0;
            valid_q <= 1'b0;
            first_q <= 1'b0;
            last_q <= 1'b0;
            byte_q <= 8'h00;
        end else begin
            valid_q <= 1'b0;
            first_q <= 1'b0;
            last_q <= 1'b0;
            case (st_q)
                lin_cmd_pkg::TX_IDLE: begin
                    if (start) begin
                        busy_q <= 1'b1;
                        st_q <= lin_cmd_pkg::TX_ID;
                    end
                end
                lin_cmd_pkg::TX_ID: begin
                    valid_q <= 1'b1;
                    first_q <= 1'b1;
                    byte_q <= lin_cmd_pkg::protect_id(raw_id);
                    idx_q <= 4'h0;
                    sum_q <= 8'h00;
                    st_q <= lin_cmd_pkg::TX_DATA;
                end
                lin_cmd_pkg::TX_DATA: begin
                    valid_q <= 1'b1;
                    byte_q <= next_byte;
                    sum_q <= lin_cmd_pkg::csum_add(sum_q, next_byte);
                    idx_q <= idx_q + 4'h1;
                    if (idx_q == nbytes - 4'h1) begin
                        st_q <= lin_cmd_pkg::TX_CHK;
                    end
                end
                lin_cmd_pkg::TX_CHK: begin
                    valid_q <= 1'b1;
                    last_q <= 1'b1;
                    byte_q <= ~sum_q;
                    busy_q <= 1'b0;
                    st_q <= lin_cmd_pkg::TX_IDLE;
                end
                default: begin
                    st_q <= lin_cmd_pkg::TX_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Port drive
    // ------------------------------------------------------------------
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign lnk.byte_valid = valid_q;
    assign lnk.byte_first = first_q;
    assign lnk.byte_last = last_q;
    assign lnk.byte_data = byte_q;

endmodule

// >>> tb/lin_frame_sva.sv
// Link checker for the frame sender and the positioner decoder.
`timescale 1ns/1ps
module lin_frame_sva (
    input logic pclk,
    input logic presetn,
    input logic byte_valid,
    input logic [7:0] byte_data,
    input logic byte_first,
    input logic byte_last,
    input logic target_load,
    input logic params_load,
    input logic frame_error,
    input logic sleep_enter,
    input logic stop_enter
);
    logic [7:0] id_q;
    logic [3:0] cnt_q;
    logic [7:0] sum_q;
    // Running checksum with the carry folded back, and the identifier parity.
    wire [8:0] sum_w = {1'b0, sum_q} + {1'b0, byte_data};
    wire [7:0] sum_d = sum_w[7:0] + {7'h00, sum_w[8]};
    wire p0 = byte_data[0] ^ byte_data[1] ^ byte_data[2] ^ byte_data[4];
    wire p1 = ~(byte_data[1] ^ byte_data[3] ^ byte_data[4] ^ byte_data[5]);
    // Tracks the identifier, the data byte count and the sum of the frame.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            id_q <= 8'h00;
            cnt_q <= 4'h0;
            sum_q <= 8'h00;
        end else if (byte_valid && byte_first) begin
            id_q <= byte_data;
            cnt_q <= 4'h0;
            sum_q <= 8'h00;
        end else if (byte_valid) begin
            cnt_q <= cnt_q + 4'h1;
            sum_q <= sum_d;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    mark_valid_a: assert property ((byte_first || byte_last) |-> byte_valid)
        else $error("Frame mark without a valid byte.");
    id_parity_a: assert property (byte_first |-> {p1, p0} == byte_data[7:6])
        else $error("Identifier parity wrong.");
    no_gap_a: assert property (byte_valid && !byte_last |=> byte_valid)
        else $error("Gap inside a frame.");
    frame_len_a: assert property (byte_last |-> cnt_q == 4'h4 || cnt_q == 4'h8)
        else $error("Bad data byte count.");
    eight_len_a: assert property (byte_last && id_q[5:4] == 2'h3 |-> cnt_q == 4'h8)
        else $error("Short or sleep frame not eight bytes.");
    sleep_fill_a: assert property (byte_valid && !byte_first && !byte_last && id_q == 8'h3c
        |-> byte_data == ((cnt_q == 4'h0) ? 8'h00 : 8'hff))
        else $error("Sleep data byte wrong.");
    csum_ok_a: assert property (byte_last |-> byte_data == ~sum_q)
        else $error("Checksum byte wrong.");
    no_error_a: assert property (byte_last |=> !frame_error)
        else $error("Good frame flagged as error.");
    load_cause_a: assert property (target_load || params_load |-> $past(byte_last))
        else $error("Load pulse without frame end.");
    one_state_a: assert property (!(sleep_enter && stop_enter))
        else $error("Sleep and stop together.");
    cover property (byte_last && id_q == 8'h3c);
    cover property (params_load);
    cover property (sleep_enter);
endmodule

// >>> tb/testbench.sv
// Bench driving the frame sender over APB and watching the positioner decoder.
`timescale 1ns/1ps
module testbench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, er, ts, tshort, pl, tl, dh, se, st, fe;
    logic permit = 1'b0;
    logic moving = 1'b0;
    logic [10:0] sec = 11'h000;
    logic clr = 1'b0;
    logic [3:0] pa;
    logic [5:0] sid, pid;
    logic [15:0] tp, tgt;
    logic [3:0] vx, vn, th, ac;
    int num_errors = 0;
    int n_checks = 0;
    int nl, np, nh, ns, nt, nf;
    lin_frame_if lnk_if ();
    lin_cmd_controller lin_cmd_controller_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .lnk(lnk_if.controller));
    lin_position_sleep_cmd_decoder lin_position_sleep_cmd_decoder_i (.pclk(pclk),
        .presetn(presetn), .lnk(lnk_if.device), .short_frame_id(sid),
        .param_frame_id(pid), .physical_address_bits(pa), .sleep_permit_flag(permit),
        .secure_position(sec), .motion_active(moving), .target_position(tp),
        .target_short(ts), .target_load(tl), .max_velocity_field(vx),
        .min_velocity_field(vn), .stall_threshold_field(th), .accel_field(ac),
        .params_load(pl), .decelerating_halt(dh), .sleep_enter(se), .stop_enter(st),
        .frame_error(fe));
    lin_frame_sva chk_i (.pclk(pclk), .presetn(presetn), .byte_valid(lnk_if.byte_valid),
        .byte_data(lnk_if.byte_data), .byte_first(lnk_if.byte_first),
        .byte_last(lnk_if.byte_last), .target_load(tl), .params_load(pl),
        .frame_error(fe), .sleep_enter(se), .stop_enter(st));
    // Clock of 25 ns.
    initial begin
        forever #12.5 pclk = ~pclk;
    end
    // Counts the decoder pulses since the last clear and keeps the last loaded target.
    always @(posedge pclk) begin
        nl <= clr ? 0 : nl + tl;
        np <= clr ? 0 : np + pl;
        nh <= clr ? 0 : nh + dh;
        ns <= clr ? 0 : ns + se;
        nt <= clr ? 0 : nt + st;
        nf <= clr ? 0 : nf + fe;
        if (tl) tgt <= tp;
        if (tl) tshort <= ts;
    end
    task automatic finish_test;
        if (num_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One APB transfer; the request holds until pready is seen high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        clr <= 1'b0;
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic idle;
        do begin
            apb(1'b0, 12'h00c, 32'h0);
        end while (rd[0] !== 1'b0);
    endtask
    // Loads data, starts a frame, waits for it to finish and settle.
    task automatic send(input logic [1:0] k, input logic [5:0] id, input logic [63:0] d);
        clr <= 1'b1;
        apb(1'b1, 12'h004, d[31:0]);
        apb(1'b1, 12'h008, d[63:32]);
        apb(1'b1, 12'h000, {1'b1, 17'h0, id, 6'h00, k});
        idle;
        repeat (4) @(posedge pclk);
        chk("frame_err", 32'h0, nf);
    endtask
    // Last pair with own address and fixed bit set gives the target.
    function automatic logic [16:0] exp_short(input logic [63:0] d);
        logic [16:0] r;
        r = 17'h0;
        for (int i = 0; i < 4; i++) begin
            if (d[16*i+4] && d[16*i+:4] == pa) r = {1'b1, {5{d[16*i+7]}}, d[16*i+5+:3],
                d[16*i+8+:8]};
        end
        return r;
    endfunction
    // Main sequence: status, unmapped access, short, parameter, sleep, refusal.
    initial begin
        logic [63:0] d;
        logic [16:0] e;
        void'($urandom(32'h7ff98343));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        pa <= 4'($urandom);
        sid <= {2'h3, 4'($urandom)};
        pid <= {2'h1, 4'($urandom)};
        @(posedge pclk);
        apb(1'b0, 12'h00c, 32'h0);
        chk("status", 32'h0, rd);
        apb(1'b1, 12'h010, 32'h1);
        chk("slverr", 32'h1, er);
        for (int i = 0; i < 8; i++) begin
            d = {$urandom, $urandom};
            for (int j = 0; j < 4; j++) if ($urandom % 2) d[16*j+:5] = {1'b1, pa};
            if (i == 1) d[7:0] = {4'h0, pa};
            if (i == 2) d[39:32] = {4'hf, pa};
            send(2'h0, (i == 0) ? sid ^ 6'h02 : sid, d);
            e = (i == 0) ? 17'h0 : exp_short(d);
            chk("short_n", e[16], nl);
            if (e[16]) chk("short_t", {e[15:0], 1'b1}, {tgt, tshort});
        end
        for (int i = 0; i < 3; i++) begin
            d = {32'h0, $urandom};
            if (i == 1) d[15:0] = 16'h0080;
            send(2'h1, pid, d);
            chk("param_n", 32'h2, nl + np);
            chk("param_t", {d[7:0], d[15:8], 1'b0}, {tgt, tshort});
            chk("param_f", {d[23:16], d[31:24]}, {vx, vn, th, ac});
        end
        for (int j = 0; j < 6; j++) begin
            permit <= j[0];
            moving <= (j > 1);
            sec <= (j > 3) ? 11'h400 : 11'($urandom) & 11'h3ff;
            send(2'h2, 6'h3c, 64'hffffffffffffff00);
            chk("sl_load", (j == 2 || j == 3), nl);
            chk("sl_halt", (j > 3), nh);
            if (j == 2 || j == 3) chk("sl_tgt", {5'h0, sec, 1'b1}, {tgt, tshort});
            if (j > 1) chk("sl_wait", 32'h0, ns + nt);
            moving <= 1'b0;
            repeat (4) @(posedge pclk);
            chk("sl_on", j[0], ns);
            chk("sl_off", !j[0], nt);
        end
        apb(1'b1, 12'h000, 32'h80001201);
        apb(1'b1, 12'h004, 32'h0);
        apb(1'b0, 12'h00c, 32'h0);
        chk("refused", 32'h1, rd[1]);
        idle;
        apb(1'b1, 12'h000, 32'h80000000);
        apb(1'b0, 12'h00c, 32'h0);
        chk("cleared", 32'h0, rd);
        finish_test;
    end
    // Watchdog against a hang.
    initial begin
        repeat (50000) @(posedge pclk);
        num_errors++;
        finish_test;
    end
endmodule
